// File: include/isc_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH
`define ISC_OFF_CTRL      8'h00
`define ISC_OFF_MASK      8'h04
`define ISC_OFF_CLKSEL    8'h08
`define ISC_OFF_STATUS    8'h0C
`define ISC_OFF_PRIO      8'h10
`define ISC_CTRL_STOP     0
`define ISC_CTRL_MODESEL  1
`define ISC_MASK_NMI0     0
`define ISC_MASK_NMI2     1
`define ISC_MASK_MI       2
`define ISC_MASK_RST      32'h0000_0000
`define ISC_CLKSEL_RST    32'h0000_0000
`define ISC_CS_SUBUSED    0
`define ISC_CS_T16WT      1
`define ISC_CS_WTPRE      2
`define ISC_CS_T8EXT      3
`define ISC_CS_T8MATCH    4
`define ISC_CS_T16IDLE    5
`define ISC_CS_THSUB      6
`define ISC_CS_WD2SUB     7
`define ISC_CS_WTMAIN     8
`define ISC_CS_CSIEXT     9
`define ISC_CS_UARTEXT    10
`define ISC_CS_RTT5       11
`define ISC_CS_T5IDLE     12
`define ISC_CS_CPUSUB     13
`define ISC_NOP_COUNT     3'h5
`endif

// File: include/isc_pkg.sv
// Types for the standby mode controller
package isc_pkg;
  typedef enum logic [1:0] {
    ISC_RUN,
    ISC_ENTER,
    ISC_IDLE
  } isc_state_t;
  typedef logic [7:0] isc_irq_t;
  typedef logic [3:0] isc_prio_t;
endpackage : isc_pkg

// File: hdl/isc_idle_ctrl.sv
// IDLE standby mode controller with AHB-Lite register slave
// Operating notes
// Register map, all single aligned words:
//   CTRL   bit0 stop request, bit1 mode select; stop cleared on wake
//   MASK   bit0 nmi pin, bit1 watchdog2 nmi, bit2 all maskable requests
//   CLKSEL bits 0..13 count-clock selections; bit0 subclock fitted
//   STATUS bit0 converter fault, bit1 entering, bit2 idle, bit3 pending
//   PRIO   bits 3:0 serviced level, bit4 in handler, bit5 enabled state
// Bus slave never stretches; every transfer has zero wait states.
// Read data comes straight from the data-phase decode, no extra flop.
// Unmapped offsets read zero and swallow writes; response is OKAY.
//
// Entry sequence:
//   Write to CTRL with stop set and mode select clear moves to ENTER.
//   ENTER counts retired NOPs from the CPU; five of them reach IDLE.
//   A wake request seen during ENTER drops straight back to RUN.
//   Counting NOPs, not cycles, keeps a stalled pipeline from entering
//   with the entering store still in flight.
//
// Release:
//   Any unmasked source, the watchdog2 interrupt only while the CPU runs on subclock, leaves IDLE on the next edge, no stabilise wait.
//   Pulses for wake, acknowledge and NMI branch follow that same edge.
//   Clock enables come back one edge after the wake pulse appears.
//   A request below the serviced level only wakes; it is left pending
//   and the sticky status bit tells software so.
//
// Reset paths:
//   The async reset pin clears everything at once, except the clock enables, which it sets high.
//   The watchdog2 reset pin acts only while the CPU runs on subclock,
//   and then clears the sequencer and software registers, but not the pending bit, synchronously.
//   Because the CLKSEL clear drops the subclock choice, a held
//   watchdog2 reset level releases itself after one cycle.
//
// Pin inputs:
//   NMI, watchdog2 reset and the eight external pins are asynchronous.
//   Three flops and a hold flop each; a level counts only when stages two and three
//   agree, so one metastable sample cannot raise a false wake.
//   The cost is four cycles of latency from pin to wake.
//   Watchdog2 interrupt and peripheral request are already on hclk.
//
// Clock gating:
//   Gate enables are flopped so a glitch in the selection decode
//   never reaches a clock gate cell downstream.
//   Enables stay high outside IDLE; selections only matter in IDLE.
//   Entry drops the enables one edge after idle_active rises.
//
// Limitations:
//   Only one pending sticky bit; several lower requests merge into it.
//   The priority compare uses a single level on req_prio; the caller
//   must present the level of the request that is actually waking.
//   Converter enables are only flagged, never forced off here.
//   HALT and STOP modes are not handled by this block.
//
// Retention:
//   RAM write block, port hold and buffer block follow idle directly,
//   so they are already set in the first IDLE cycle.
//   The oscillator and key interrupt clock are never gated.
//
// Verification hooks:
//   All outputs are ports so the checker sees them without reaching in.
//   Wake and reset pulses are single cycle for easy counting.
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "isc_consts.svh"

module isc_idle_ctrl (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                nmi_pin,
  input  wire logic                watchdog2_interrupt,
  input  wire isc_pkg::isc_irq_t   external_irq_pins,
  input  wire isc_pkg::isc_irq_t   external_irq_mask,
  input  wire logic                periph_irq,
  input  wire isc_pkg::isc_prio_t  req_prio,
  input  wire logic                watchdog2_reset,
  input  wire logic                cpu_nop_retire,
  input  wire logic                converter_enable_bit,
  input  wire logic                converter_enable_bit2,
  output logic                     cpu_clk_en,
  output logic                     periph_clk_en,
  output logic                     osc_enable,
  output logic                     idle_active,
  output logic                     wake_pulse,
  output logic                     wake_ack,
  output logic                     wake_branch_nmi,
  output logic                     sync_reset,
  output logic                     ram_write_block,
  output logic                     port_hold,
  output logic                     key_irq_clk_en,
  output logic                     timer16_clk_en,
  output logic                     timer8_clk_en,
  output logic                     timer_h1_clk_en,
  output logic                     watchdog2_clk_en,
  output logic                     watch_timer_clk_en,
  output logic                     serial_clk_en,
  output logic                     async_serial_channel0_clk_en,
  output logic                     rt_output_clk_en,
  output logic                     rt_buffer_write_block,
  output logic                     watch_timer_prescaler_sel,
  output logic                     converter_fault
);
  import isc_pkg::*;

  // Pin synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [9:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
  wire  [9:0] pin_raw = {nmi_pin, watchdog2_reset, external_irq_pins};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg <= 10'h000;
      pin_s2_reg <= 10'h000;
      pin_s3_reg <= 10'h000;
      pin_reg    <= 10'h000;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_reg    <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));
    end
  end
  wire       nmi_sync  = pin_reg[9];
  wire       wd2r_sync = pin_reg[8];
  isc_irq_t ext_sync;
  assign ext_sync = pin_reg[7:0];

  // Registers
  logic       stop_request_bit_reg, power_mode_select_bit_reg;
  logic [2:0] mask_reg;
  logic [13:0] clksel_reg;
  isc_prio_t  serv_prio_reg;
  logic       in_isr_reg, ie_reg;
  isc_state_t state_reg, state_next;
  logic [2:0] nop_cnt_reg;
  logic       wake_pending_reg;

  // AHB-Lite address phase capture
  logic       dp_valid_reg, dp_write_reg;
  logic [7:0] dp_addr_reg;
  wire        ap_take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end else if (hready) begin
      dp_valid_reg <= ap_take;
      dp_write_reg <= hwrite;
      dp_addr_reg  <= haddr[7:0];
    end
  end

  // Decode, shared by read mux and write strobes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit
  wire wr = dp_valid_reg & dp_write_reg;
  wire wr_ctrl   = wr & hit(dp_addr_reg, `ISC_OFF_CTRL);
  wire wr_mask   = wr & hit(dp_addr_reg, `ISC_OFF_MASK);
  wire wr_clksel = wr & hit(dp_addr_reg, `ISC_OFF_CLKSEL);
  wire wr_prio   = wr & hit(dp_addr_reg, `ISC_OFF_PRIO);

  // Subclock selections and CPU clock source
  wire sub_used = clksel_reg[`ISC_CS_SUBUSED];
  wire cpu_sub  = sub_used & clksel_reg[`ISC_CS_CPUSUB];

  // Wake sources; masked ones never release
  wire nmi_src  = (nmi_sync & ~mask_reg[`ISC_MASK_NMI0]) |
                  (watchdog2_interrupt & cpu_sub & ~mask_reg[`ISC_MASK_NMI2]);
  wire mi_src   = ~mask_reg[`ISC_MASK_MI] &
                  ((|(ext_sync & ~external_irq_mask)) | periph_irq);
  wire wake_req = nmi_src | mi_src;
  wire rst_req  = wd2r_sync & cpu_sub;

  // Entry: stop request with mode select cleared
  wire enter_req = wr_ctrl & hwdata[`ISC_CTRL_STOP] & ~hwdata[`ISC_CTRL_MODESEL];

  // Mode sequencer; oscillator never stops so wake is immediate
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ISC_RUN:   if (enter_req) state_next = ISC_ENTER;
      ISC_ENTER: if (wake_req) state_next = ISC_RUN;
                 else if (nop_cnt_reg == `ISC_NOP_COUNT) state_next = ISC_IDLE;
      ISC_IDLE:  if (wake_req) state_next = ISC_RUN;
    endcase
  end

  // Sequencer, NOP count and reset-like release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg   <= ISC_RUN;
      nop_cnt_reg <= 3'h0;
    end else if (rst_req) begin
      state_reg   <= ISC_RUN;
      nop_cnt_reg <= 3'h0;
    end else begin
      state_reg   <= state_next;
      if (state_reg != ISC_ENTER)
        nop_cnt_reg <= 3'h0;
      else if (cpu_nop_retire && nop_cnt_reg != `ISC_NOP_COUNT)
        nop_cnt_reg <= nop_cnt_reg + 3'h1;
    end
  end

  // Software registers; stop bit cleared by hardware on wake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_request_bit_reg      <= 1'b0;
      power_mode_select_bit_reg <= 1'b0;
      mask_reg                  <= 3'(`ISC_MASK_RST);
      clksel_reg                <= 14'(`ISC_CLKSEL_RST);
      serv_prio_reg             <= 4'h0;
      in_isr_reg                <= 1'b0;
      ie_reg                    <= 1'b0;
    end else if (rst_req) begin
      stop_request_bit_reg      <= 1'b0;
      power_mode_select_bit_reg <= 1'b0;
      mask_reg                  <= 3'(`ISC_MASK_RST);
      clksel_reg                <= 14'(`ISC_CLKSEL_RST);
      serv_prio_reg             <= 4'h0;
      in_isr_reg                <= 1'b0;
      ie_reg                    <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        stop_request_bit_reg      <= hwdata[`ISC_CTRL_STOP];
        power_mode_select_bit_reg <= hwdata[`ISC_CTRL_MODESEL];
      end
      if (state_reg != ISC_RUN && state_next == ISC_RUN)
        stop_request_bit_reg <= 1'b0;
      if (wr_mask) mask_reg <= hwdata[2:0];
      if (wr_clksel) clksel_reg <= hwdata[13:0];
      if (wr_prio) begin
        serv_prio_reg <= hwdata[3:0];
        in_isr_reg    <= hwdata[4];
        ie_reg        <= hwdata[5];
      end
    end
  end

  // Wake decision: acknowledge NMI, or an enabled request when outside a handler or above serviced level
  wire waking  = (state_reg != ISC_RUN) & wake_req & ~rst_req;
  wire higher  = ~in_isr_reg | (req_prio < serv_prio_reg);
  wire ack_nmi = nmi_src;
  wire ack_mi  = mi_src & ie_reg & higher;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_pulse      <= 1'b0;
      wake_ack        <= 1'b0;
      wake_branch_nmi <= 1'b0;
      sync_reset      <= 1'b0;
    end else begin
      wake_pulse      <= waking;
      wake_ack        <= waking & (ack_nmi | ack_mi);
      wake_branch_nmi <= waking & ack_nmi;
      sync_reset      <= rst_req;
    end
  end

  // Clock gates while idle
  wire idle = (state_reg == ISC_IDLE);
  wire cs_t16wt = clksel_reg[`ISC_CS_T16WT];
  wire cs_wtpre = clksel_reg[`ISC_CS_WTPRE];
  wire t16_on   = cs_t16wt & (sub_used | cs_wtpre);
  // Match clocking also needs the 16-bit timer enabled for IDLE
  wire t8_on    = clksel_reg[`ISC_CS_T8EXT] |
                  (clksel_reg[`ISC_CS_T8MATCH] & t16_on &
                   clksel_reg[`ISC_CS_T16IDLE]);
  wire th1_on   = sub_used & clksel_reg[`ISC_CS_THSUB];
  wire wd2_on   = sub_used & clksel_reg[`ISC_CS_WD2SUB];
  wire wt_on    = sub_used | clksel_reg[`ISC_CS_WTMAIN];
  wire rt_on    = clksel_reg[`ISC_CS_RTT5] & clksel_reg[`ISC_CS_T5IDLE];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_clk_en            <= 1'b1;
      periph_clk_en         <= 1'b1;
      timer16_clk_en        <= 1'b1;
      timer8_clk_en         <= 1'b1;
      timer_h1_clk_en       <= 1'b1;
      watchdog2_clk_en      <= 1'b1;
      watch_timer_clk_en    <= 1'b1;
      serial_clk_en         <= 1'b1;
      async_serial_channel0_clk_en <= 1'b1;
      rt_output_clk_en      <= 1'b1;
    end else begin
      cpu_clk_en            <= ~idle;
      periph_clk_en         <= ~idle;
      timer16_clk_en        <= ~idle | t16_on;
      timer8_clk_en         <= ~idle | t8_on;
      timer_h1_clk_en       <= ~idle | th1_on;
      watchdog2_clk_en      <= ~idle | wd2_on;
      watch_timer_clk_en    <= ~idle | wt_on;
      serial_clk_en         <= ~idle | clksel_reg[`ISC_CS_CSIEXT];
      async_serial_channel0_clk_en <= ~idle | clksel_reg[`ISC_CS_UARTEXT];
      rt_output_clk_en      <= ~idle | rt_on;
    end
  end

  // Static outputs; hold and retention follow idle state
  assign osc_enable                = 1'b1;
  assign key_irq_clk_en            = 1'b1;
  assign idle_active               = idle;
  assign ram_write_block           = idle;
  assign port_hold                 = idle;
  assign rt_buffer_write_block     = idle;
  assign watch_timer_prescaler_sel = ~sub_used & cs_wtpre;
  // Converter left running at entry is flagged for software
  assign converter_fault = (state_reg != ISC_RUN) &
                           (converter_enable_bit | converter_enable_bit2);

  // Read mux; unmapped reads zero, response always OKAY
  wire [31:0] rd_status = {28'h0000000, wake_pending_reg, idle,
                           state_reg == ISC_ENTER, converter_fault};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_pending_reg <= 1'b0;
    end else begin
      // Set wins over the clear done by a status read
      if (waking & ~(ack_nmi | ack_mi))
        wake_pending_reg <= 1'b1;
      else if (dp_valid_reg & ~dp_write_reg & hit(dp_addr_reg, `ISC_OFF_STATUS))
        wake_pending_reg <= 1'b0;
    end
  end
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_valid_reg & ~dp_write_reg) begin
      if (hit(dp_addr_reg, `ISC_OFF_CTRL))
        hrdata = {30'h0000_0000, power_mode_select_bit_reg, stop_request_bit_reg};
      else if (hit(dp_addr_reg, `ISC_OFF_MASK))
        hrdata = {29'h0000_0000, mask_reg};
      else if (hit(dp_addr_reg, `ISC_OFF_CLKSEL))
        hrdata = {18'h00000, clksel_reg};
      else if (hit(dp_addr_reg, `ISC_OFF_STATUS))
        hrdata = rd_status;
      else if (hit(dp_addr_reg, `ISC_OFF_PRIO))
        hrdata = {26'h0000000, ie_reg, in_isr_reg, serv_prio_reg};
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule : isc_idle_ctrl

// File: testbench/isc_cpu_model.sv
// Behavioural CPU model that retires the NOPs following the entering store
`timescale 1ns/1ps
module isc_cpu_model #(
  parameter int GAP = 2
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic go,
  output logic      nop_retire
);
  int left_reg;
  int wait_reg;
  // Spaced pulses, so an early entry after four NOPs cannot hide in a burst
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_reg   <= 0;
      wait_reg   <= 0;
      nop_retire <= 1'b0;
    end else begin
      nop_retire <= 1'b0;
      if (go) begin
        left_reg <= 5;
        wait_reg <= GAP;
      end else if (left_reg > 0 && wait_reg > 0) begin
        wait_reg <= wait_reg - 1;
      end else if (left_reg > 0) begin
        nop_retire <= 1'b1;
        left_reg   <= left_reg - 1;
        wait_reg   <= GAP;
      end
    end
  end
endmodule : isc_cpu_model

// File: testbench/isc_idle_props.sv
// Concurrent checks on the standby controller outputs
`timescale 1ns/1ps
module isc_idle_props (
  input wire logic hclk, hresetn, converter_enable_bit, converter_enable_bit2,
  input wire logic cpu_clk_en, periph_clk_en, osc_enable, idle_active, wake_pulse,
  input wire logic wake_branch_nmi, sync_reset, ram_write_block, port_hold,
  input wire logic key_irq_clk_en, rt_buffer_write_block, converter_fault
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  osc_run_a: assert property (osc_enable && key_irq_clk_en)
    else $error("oscillator or key clock stopped");
  entry_gate_a: assert property ($rose(idle_active) |=> !cpu_clk_en && !periph_clk_en)
    else $error("clocks still running after entry");
  idle_stop_a: assert property (idle_active && $past(idle_active) |-> !cpu_clk_en)
    else $error("cpu clock running in idle");
  idle_hold_a: assert property (idle_active |-> ram_write_block && port_hold)
    else $error("state not held in idle");
  rt_block_a: assert property (idle_active |-> rt_buffer_write_block)
    else $error("output buffer writable in idle");
  wake_clk_a: assert property (wake_pulse |=> cpu_clk_en && periph_clk_en)
    else $error("clocks not back at wake");
  wake_quick_a: assert property ($fell(idle_active) |-> ##[0:1] (wake_pulse || sync_reset))
    else $error("release slow or silent");
  pulse_one_a: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse too long");
  conv_flag_a: assert property (idle_active && (converter_enable_bit || converter_enable_bit2)
    |-> converter_fault)
    else $error("converter left enabled unflagged");
  entry_c: cover property ($rose(idle_active));
  wake_c: cover property (wake_pulse);
  nmi_c: cover property (wake_branch_nmi);
endmodule : isc_idle_props

bind isc_idle_ctrl isc_idle_props i_props (.hclk(hclk), .hresetn(hresetn),
  .converter_enable_bit(converter_enable_bit), .converter_enable_bit2(converter_enable_bit2),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
  .idle_active(idle_active), .wake_pulse(wake_pulse), .wake_branch_nmi(wake_branch_nmi),
  .sync_reset(sync_reset), .ram_write_block(ram_write_block), .port_hold(port_hold),
  .key_irq_clk_en(key_irq_clk_en), .rt_buffer_write_block(rt_buffer_write_block),
  .converter_fault(converter_fault));

// File: testbench/tb.sv
// Self-checking bench for the IDLE standby controller
`timescale 1ns/1ps
`include "isc_consts.svh"
module tb;
  import isc_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, cv = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [11:0] src = 12'h000;  // 7:0 pins, 8 nmi, 9 wd2 irq, 10 periph, 11 wd2 reset
  isc_irq_t    emask = 8'h00;
  isc_prio_t   pr = 4'h0;
  logic        hrdy, hresp, nop, cpu, per, osc, idl, wp, wa, wbn, srst, rwb, ph, key;
  logic        t16, t8, th1, wd2, wt, ser, u0, rt, rbw, wps, cf;
  int          fails = 0, num_checks = 0, cyc = 0, n_nop = 0, n_ack = 0, n_nmi = 0;
  int          n_srst = 0, base;
  logic [31:0] cfgs [3] = '{32'h0, 32'h1ECB, 32'h102};
  logic [9:0]  exps [3] = '{10'h000, 10'h0FF, 10'h008};
  logic [31:0] pv [5] = '{32'h34, 32'h34, 32'h20, 32'h04, 32'h34};
  isc_prio_t   rq [5] = '{4'h2, 4'h6, 4'h9, 4'h2, 4'h6};
  logic [11:0] sv [5] = '{12'h400, 12'h400, 12'h400, 12'h400, 12'h100};
  logic [11:0] ms [4] = '{12'h100, 12'h200, 12'h001, 12'h400};
  int          av [5] = '{1, 0, 1, 0, 1};

  isc_idle_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .nmi_pin(src[8]),
    .watchdog2_interrupt(src[9]), .external_irq_pins(src[7:0]), .external_irq_mask(emask),
    .periph_irq(src[10]), .req_prio(pr), .watchdog2_reset(src[11]), .cpu_nop_retire(nop),
    .converter_enable_bit(cv), .converter_enable_bit2(cv), .cpu_clk_en(cpu),
    .periph_clk_en(per), .osc_enable(osc), .idle_active(idl), .wake_pulse(wp),
    .wake_ack(wa), .wake_branch_nmi(wbn), .sync_reset(srst), .ram_write_block(rwb),
    .port_hold(ph), .key_irq_clk_en(key), .timer16_clk_en(t16), .timer8_clk_en(t8),
    .timer_h1_clk_en(th1), .watchdog2_clk_en(wd2), .watch_timer_clk_en(wt),
    .serial_clk_en(ser), .async_serial_channel0_clk_en(u0), .rt_output_clk_en(rt),
    .rt_buffer_write_block(rbw), .watch_timer_prescaler_sel(wps), .converter_fault(cf));
  isc_cpu_model #(.GAP(2)) i_cpu (.hclk(hclk), .hresetn(hresetn), .go(go), .nop_retire(nop));

  always #2 hclk = ~hclk;
  // Event counters and the hang limit
  always @(posedge hclk) begin
    cyc++;
    n_nop += nop;
    n_ack += wa;
    n_nmi += wbn;
    n_srst += srst;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(negedge hclk);
  endtask : cycles

  // Address phase held until hready, then data phase held until hready again
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hrdy !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : bus

  // Stop request with mode select cleared, then the CPU retires its NOPs
  task automatic go_idle(input logic [31:0] cfg);
    bus(1'b1, `ISC_OFF_CLKSEL, cfg);
    bus(1'b1, `ISC_OFF_CTRL, 32'h1);
    base = n_nop;
    go <= 1'b1;
    @(posedge hclk) go <= 1'b0;
    repeat (60) if (idl !== 1'b1) @(negedge hclk);
    chk("nops before idle", n_nop - base, 5);
    chk("idle entered", idl, 1'b1);
    cycles(2);
  endtask : go_idle

  // Level request held long enough to cross the pin synchroniser
  task automatic poke(input logic [11:0] s, input logic w);
    @(posedge hclk) src <= s;
    cycles(12);
    chk("woken", !idl, w);
    @(posedge hclk) src <= 12'h000;
    cycles(4);
  endtask : poke

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `ISC_OFF_MASK, 0);
    chk("mask reset", rd, `ISC_MASK_RST);
    bus(1'b0, `ISC_OFF_CLKSEL, 0);
    chk("clksel reset", rd, `ISC_CLKSEL_RST);
    bus(1'b1, 32'h40, 32'hFFFF_FFFF);
    bus(1'b0, 32'h40, 0);
    chk("unmapped", rd, 0);
    bus(1'b1, `ISC_OFF_CTRL, 32'h3);
    go <= 1'b1;
    @(posedge hclk) go <= 1'b0;
    cycles(30);
    chk("mode select set", idl, 0);
    bus(1'b1, `ISC_OFF_CTRL, 0);
    // Gating per count-clock selection, then a wake with interrupts disabled
    for (int i = 0; i < 3; i++) begin
      go_idle(cfgs[i]);
      chk("clock gates", {cpu, per, t16, t8, th1, wd2, wt, ser, u0, rt}, exps[i]);
      chk("held state", {osc, key, rwb, ph, rbw}, 5'h1F);
      @(posedge hclk) cv <= 1'b1;
      cycles(1);
      chk("converter", cf, 1);
      @(posedge hclk) cv <= 1'b0;
      base = n_nmi;
      poke(12'h100, 1'b1);
      chk("nmi branch", n_nmi - base, 1);
      chk("clocks back", {cpu, per}, 2'h3);
    end
    bus(1'b1, `ISC_OFF_MASK, 32'h7);
    emask <= 8'h01;
    go_idle(0);
    foreach (ms[i]) poke(ms[i], 1'b0);
    bus(1'b1, `ISC_OFF_MASK, 0);
    emask <= 8'h00;
    poke(12'h080, 1'b1);
    // Acknowledge by priority and enable state
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, `ISC_OFF_PRIO, pv[i]);
      pr <= rq[i];
      go_idle(0);
      base = n_ack;
      poke(sv[i], 1'b1);
      chk("ack", n_ack - base, av[i]);
      if (i == 1) begin
        bus(1'b0, `ISC_OFF_STATUS, 0);
        chk("wake no ack", rd[3], 1);
      end
    end
    bus(1'b1, `ISC_OFF_PRIO, 0);
    go_idle(32'h2001);
    poke(12'h200, 1'b1);
    go_idle(32'h2001);
    base = n_srst;
    @(posedge hclk) src <= 12'h800;
    cycles(12);
    chk("wd2 reset", {n_srst > base, idl}, 2'b10);
    @(posedge hclk) src <= 12'h000;
    go_idle(0);
    @(posedge hclk) hresetn <= 1'b0;
    cycles(2);
    chk("reset state", {idl, cpu, per}, 3'b011);
    @(posedge hclk) hresetn <= 1'b1;
    bus(1'b0, `ISC_OFF_CTRL, 0);
    chk("ctrl after reset", rd, 0);
    results();
  end
endmodule : tb
